// [logic/sled_diag.sv]
// Operation
// - The output-state lamp is lit while the safety outputs are active and dark otherwise.
// - The start lamp is dark when unmet, lit when met and flashing while waiting.
// - Each input lamp follows its input, lit when active, outside alert or error display.
// - An alert flashes the fault lamp and the involved input lamps and forces the safe state.
// - A synchronization alert flashes the two input lamps in opposite phase.
// - An interlock alert flashes both input lamps in phase and blocks outputs until 1 s idle.
// - A detected error lights the fault lamp solid and latches the safe state until reset.
// - General error flashes state, start and inputs together; configuration error lights them.
// - A supply error keeps the fault lamp solid and flashes the power lamp.
// - An own output error keeps the fault lamp solid and flashes the state lamp.
// - A start input cross circuit keeps the fault lamp solid and flashes the start lamp.
// - An extension output error flashes the state and start lamps together.
// - A single input cross circuit flashes that input's lamp.
// - A cross circuit of two inputs flashes both input lamps in phase.
// - Selectors are taken once after power-up and any later change is a configuration error.
`timescale 1ns/1ps

module sled_diag #(
  parameter int LOCK_OFF_CYC   = sled_pkg::LOCK_OFF_CYC,
  parameter int BLINK_HALF_CYC = sled_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input  wire logic                             mclk,
  input  wire logic                             srst,
  // safety core
  input  wire sled_pkg::sled_status_type        status,
  input  wire sled_pkg::sled_alert_type         alert,
  input  wire sled_pkg::sled_error_type         error,
  // selector pins
  input  wire logic [sled_pkg::SEL_W-1:0]       sel_app_pin,
  input  wire logic [sled_pkg::SEL_W-1:0]       sel_start_pin,
  // register port
  input  wire logic [sled_pkg::ADDR_W-1:0]      reg_addr,
  input  wire logic [sled_pkg::DATA_W-1:0]      reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [sled_pkg::DATA_W-1:0]      reg_rdata,
  // lamps and core feedback
  output sled_pkg::sled_lamp_type               lamps,
  output logic                                  safe_state,
  output logic                                  irq
);

  localparam int N      = sled_pkg::NUM_INPUTS;
  localparam int BW     = $clog2(BLINK_HALF_CYC + 1);
  localparam int LW     = $clog2(LOCK_OFF_CYC + 1);
  localparam int SW     = 2 * sled_pkg::SEL_W;
  localparam int LAMP_W = sled_pkg::LAMP_IN0 + N;

  // ****************************************************************
  // blink source
  // ****************************************************************
  logic [BW-1:0] blink_cnt_q;
  logic          blink_tick;
  logic          blink_q;

  // one divider for every flashing lamp keeps all phases locked
  assign blink_tick = (blink_cnt_q == BW'(BLINK_HALF_CYC - 1));

  always_ff @(posedge mclk) begin
    if (srst || blink_tick) begin
      blink_cnt_q <= '0;
    end else begin
      blink_cnt_q <= blink_cnt_q + BW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      blink_q <= 1'b0;
    end else if (blink_tick) begin
      blink_q <= ~blink_q;
    end
  end

  // ****************************************************************
  // selector capture
  // ****************************************************************
  logic [SW-1:0] sel_meta_q;
  logic [SW-1:0] sel_sync_q;
  logic [SW-1:0] sel_cap_q;
  logic [1:0]    settle_q;
  logic          sel_valid_q;
  logic          cfg_err;

  always_ff @(posedge mclk) begin
    if (srst) begin
      sel_meta_q <= '0;
      sel_sync_q <= '0;
    end else begin
      sel_meta_q <= {sel_app_pin, sel_start_pin};
      sel_sync_q <= sel_meta_q;
    end
  end

  // wait for the synchroniser to fill before taking the positions
  always_ff @(posedge mclk) begin
    if (srst) begin
      settle_q    <= '0;
      sel_valid_q <= 1'b0;
      sel_cap_q   <= '0;
    end else if (!sel_valid_q) begin
      if (settle_q == 2'(sled_pkg::SYNC_STAGES)) begin
        sel_valid_q <= 1'b1;
        sel_cap_q   <= sel_sync_q;
      end else begin
        settle_q <= settle_q + 2'(1);
      end
    end
  end

  assign cfg_err = sel_valid_q && (sel_sync_q != sel_cap_q);

  // ****************************************************************
  // error latch
  // ****************************************************************
  logic [sled_pkg::ERR_W-1:0] err_q;
  logic [N-1:0]               err_in_q;
  logic                       err_any;

  // cleared only by the power-up reset, never by software
  always_ff @(posedge mclk) begin
    if (srst) begin
      err_q    <= '0;
      err_in_q <= '0;
    end else begin
      err_q[sled_pkg::ERR_GENERAL] <= err_q[sled_pkg::ERR_GENERAL] | error.general;
      err_q[sled_pkg::ERR_CONFIG]  <= err_q[sled_pkg::ERR_CONFIG] | cfg_err;
      err_q[sled_pkg::ERR_POWER]   <= err_q[sled_pkg::ERR_POWER] | error.power;
      err_q[sled_pkg::ERR_OUTPUT]  <= err_q[sled_pkg::ERR_OUTPUT] | error.output_fail;
      err_q[sled_pkg::ERR_EXT_OUT] <= err_q[sled_pkg::ERR_EXT_OUT] | error.ext_output_fail;
      err_q[sled_pkg::ERR_START_X] <= err_q[sled_pkg::ERR_START_X] | error.start_cross;
      err_q[sled_pkg::ERR_INPUT_X] <= err_q[sled_pkg::ERR_INPUT_X] | (|error.input_cross);
      err_in_q                     <= err_in_q | error.input_cross;
    end
  end

  assign err_any = |err_q;

  // ****************************************************************
  // interlock hold-off
  // ****************************************************************
  logic [LW-1:0] lock_cnt_q;
  logic [N-1:0]  lock_mask_q;
  logic          lock_hold_q;
  logic          lock_quiet;
  logic          lock_done;

  assign lock_quiet = ~alert.lock_alert && ((status.input_active & lock_mask_q) == '0);
  assign lock_done  = lock_hold_q && lock_quiet && (lock_cnt_q == LW'(LOCK_OFF_CYC - 1));

  always_ff @(posedge mclk) begin
    if (srst) begin
      lock_hold_q <= 1'b0;
      lock_mask_q <= '0;
      lock_cnt_q  <= '0;
    end else if (alert.lock_alert) begin
      // a second interlock on other inputs only widens the mask
      lock_hold_q <= 1'b1;
      lock_mask_q <= lock_mask_q | alert.inputs;
      lock_cnt_q  <= '0;
    end else if (!lock_hold_q || !lock_quiet) begin
      lock_cnt_q <= '0;
    end else if (lock_done) begin
      lock_hold_q <= 1'b0;
      lock_mask_q <= '0;
      lock_cnt_q  <= '0;
    end else begin
      lock_cnt_q <= lock_cnt_q + LW'(1);
    end
  end

  // ****************************************************************
  // safe state
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      safe_state <= 1'b1;
    end else begin
      // alerts release by themselves, errors never do
      safe_state <= err_any | alert.sync_alert | alert.lock_alert | lock_hold_q;
    end
  end

  // ****************************************************************
  // lamp selection
  // ****************************************************************
  sled_pkg::sled_lamp_type lamp_d;
  logic [N-1:0]            odd_pos;

  // pairs are neighbouring inputs; the odd one of a pair runs inverted
  always_comb begin
    for (int i = 0; i < N; i++) begin
      odd_pos[i] = (i % 2) == 1;
    end
  end

  always_comb begin
    lamp_d        = '0;
    lamp_d.power  = 1'b1;
    lamp_d.state  = status.outputs_active;
    lamp_d.start  = status.start_met | (status.start_wait & blink_q);
    lamp_d.inputs = status.input_active;
    if (err_any) begin
      // the latched error with the lowest index decides the picture
      lamp_d.fault  = 1'b1;
      lamp_d.state  = 1'b0;
      lamp_d.start  = 1'b0;
      lamp_d.inputs = '0;
      if (err_q[sled_pkg::ERR_GENERAL]) begin
        lamp_d.state  = blink_q;
        lamp_d.start  = blink_q;
        lamp_d.inputs = {N{blink_q}};
      end else if (err_q[sled_pkg::ERR_CONFIG]) begin
        lamp_d.state  = 1'b1;
        lamp_d.start  = 1'b1;
        lamp_d.inputs = '1;
      end else if (err_q[sled_pkg::ERR_POWER]) begin
        lamp_d.power = blink_q;
      end else if (err_q[sled_pkg::ERR_OUTPUT]) begin
        lamp_d.state = blink_q;
      end else if (err_q[sled_pkg::ERR_EXT_OUT]) begin
        lamp_d.state = blink_q;
        lamp_d.start = blink_q;
      end else if (err_q[sled_pkg::ERR_START_X]) begin
        lamp_d.start = blink_q;
      end else begin
        lamp_d.inputs = err_in_q & {N{blink_q}};
      end
    end else if (alert.sync_alert) begin
      lamp_d.fault = blink_q;
      for (int i = 0; i < N; i++) begin
        if (alert.inputs[i]) begin
          lamp_d.inputs[i] = blink_q ^ odd_pos[i];
        end
      end
    end else if (alert.lock_alert) begin
      lamp_d.fault  = blink_q;
      lamp_d.inputs = (status.input_active & ~alert.inputs) | (alert.inputs & {N{blink_q}});
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      lamps <= '0;
    end else begin
      lamps <= lamp_d;
    end
  end

  // ****************************************************************
  // interrupt status
  // ****************************************************************
  logic [sled_pkg::IRQ_W-1:0] irq_stat_q;
  logic [sled_pkg::IRQ_W-1:0] irq_en_q;
  logic [sled_pkg::IRQ_W-1:0] irq_set;
  logic [sled_pkg::IRQ_W-1:0] irq_clr;
  logic [sled_pkg::IRQ_W-1:0] irq_stat_d;
  logic [sled_pkg::IRQ_W-1:0] irq_en_d;
  logic                       err_any_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      err_any_q <= 1'b0;
    end else begin
      err_any_q <= err_any;
    end
  end

  always_comb begin
    irq_set                          = '0;
    irq_set[sled_pkg::IRQ_SYNC]      = alert.sync_alert;
    irq_set[sled_pkg::IRQ_LOCK]      = alert.lock_alert;
    irq_set[sled_pkg::IRQ_ERROR]     = err_any & ~err_any_q;
    irq_set[sled_pkg::IRQ_LOCK_DONE] = lock_done;
  end

  assign irq_clr = (reg_wr && reg_addr == sled_pkg::REG_IRQ_CLEAR) ?
                   reg_wdata[sled_pkg::IRQ_W-1:0] : '0;

  // a new event in the clearing cycle survives
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  assign irq_en_d = (reg_wr && reg_addr == sled_pkg::REG_IRQ_ENABLE) ?
                    reg_wdata[sled_pkg::IRQ_W-1:0] : irq_en_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_en_q <= sled_pkg::IRQ_ENABLE_RST;
    end else begin
      irq_en_q <= irq_en_d;
    end
  end

  // built from next values so the pin moves with the status bits and never glitches
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_d & irq_en_d);
    end
  end

  // ****************************************************************
  // register read
  // ****************************************************************
  logic [sled_pkg::DATA_W-1:0] rd_d;

  always_comb begin
    rd_d = '0;
    if (reg_addr == sled_pkg::REG_IRQ_STATUS) begin
      rd_d[sled_pkg::IRQ_W-1:0] = irq_stat_q;
    end else if (reg_addr == sled_pkg::REG_IRQ_ENABLE) begin
      rd_d[sled_pkg::IRQ_W-1:0] = irq_en_q;
    end else if (reg_addr == sled_pkg::REG_LAMPS) begin
      rd_d[LAMP_W-1:0] = {lamps.inputs, lamps.start, lamps.state, lamps.fault, lamps.power};
    end else if (reg_addr == sled_pkg::REG_SELECT) begin
      rd_d[SW-1:0] = sel_cap_q;
      rd_d[SW]     = sel_valid_q;
    end else if (reg_addr == sled_pkg::REG_ERRORS) begin
      rd_d[sled_pkg::ERR_W-1:0]     = err_q;
      rd_d[sled_pkg::ERR_W+N-1 -: N] = err_in_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : sled_diag

// [logic/sled_pkg.sv]
package sled_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_INPUTS = 6;
  localparam int SEL_W      = 4;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int SYNC_STAGES = 2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint CLK_HZ        = 64'd20_000_000;
  localparam longint LOCK_OFF_MS   = 64'd1000;
  localparam longint BLINK_HALF_MS = 64'd500;
  localparam int LOCK_OFF_CYC   = int'((LOCK_OFF_MS * CLK_HZ + 64'd999) / 64'd1000);
  localparam int BLINK_HALF_CYC = int'((BLINK_HALF_MS * CLK_HZ) / 64'd1000);

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h08;
  localparam logic [ADDR_W-1:0] REG_LAMPS      = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_SELECT     = 8'h10;
  localparam logic [ADDR_W-1:0] REG_ERRORS     = 8'h14;

  // irq status bits
  localparam int IRQ_W         = 4;
  localparam int IRQ_SYNC      = 0;
  localparam int IRQ_LOCK      = 1;
  localparam int IRQ_ERROR     = 2;
  localparam int IRQ_LOCK_DONE = 3;
  localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST = 4'h0;

  // latched error bits, lowest index shown first
  localparam int ERR_W       = 7;
  localparam int ERR_GENERAL = 0;
  localparam int ERR_CONFIG  = 1;
  localparam int ERR_POWER   = 2;
  localparam int ERR_OUTPUT  = 3;
  localparam int ERR_EXT_OUT = 4;
  localparam int ERR_START_X = 5;
  localparam int ERR_INPUT_X = 6;

  // lamp word layout
  localparam int LAMP_POWER = 0;
  localparam int LAMP_FAULT = 1;
  localparam int LAMP_STATE = 2;
  localparam int LAMP_START = 3;
  localparam int LAMP_IN0   = 4;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic                  outputs_active;
    logic                  start_met;
    logic                  start_wait;
    logic [NUM_INPUTS-1:0] input_active;
  } sled_status_type;

  typedef struct packed {
    logic                  sync_alert;
    logic                  lock_alert;
    logic [NUM_INPUTS-1:0] inputs;
  } sled_alert_type;

  typedef struct packed {
    logic                  general;
    logic                  power;
    logic                  output_fail;
    logic                  ext_output_fail;
    logic                  start_cross;
    logic [NUM_INPUTS-1:0] input_cross;
  } sled_error_type;

  typedef struct packed {
    logic                  power;
    logic                  fault;
    logic                  state;
    logic                  start;
    logic [NUM_INPUTS-1:0] inputs;
  } sled_lamp_type;

endpackage : sled_pkg

// [verif/sled_diag_asserts.sv]
`timescale 1ns/1ps
// ****************************************************************
// lamp and safe-state checker
// ****************************************************************
module sled_diag_asserts #(
  parameter int BLINK_HALF_CYC = 4
) (
  // clock and reset
  input wire logic                      mclk,
  input wire logic                      srst,
  // safety core
  input wire sled_pkg::sled_status_type status,
  input wire sled_pkg::sled_alert_type  alert,
  input wire sled_pkg::sled_error_type  error,
  // lamps
  input wire sled_pkg::sled_lamp_type   lamps,
  input wire logic                      safe_state
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  logic err_q;
  logic ok;
  logic calm;
  int   run_q;
  int   hi_q;

  // config errors are invisible here, so status checks accept a lit fault lamp
  assign ok   = !err_q && !(|error);
  assign calm = ok && !alert.sync_alert && !alert.lock_alert;

  always_ff @(posedge mclk) begin
    if (srst) err_q <= 1'b0;
    else if (|error) err_q <= 1'b1;
  end
  always_ff @(posedge mclk) begin
    run_q <= (calm && status.start_wait && !srst) ? run_q + 1 : 0;
  end
  always_ff @(posedge mclk) begin
    hi_q <= lamps.start ? hi_q + 1 : 0;
  end

  sequence s_sync;
    alert.sync_alert && alert.inputs[1:0] == 2'b11 && ok;
  endsequence
  sequence s_lock;
    alert.lock_alert && !alert.sync_alert && alert.inputs[3:2] == 2'b11 && ok;
  endsequence

  property p_state;
    calm |=> lamps.fault || lamps.state == $past(status.outputs_active);
  endproperty
  property p_start;
    calm && !status.start_wait |=> lamps.fault || lamps.start == $past(status.start_met);
  endproperty
  property p_inputs;
    calm |=> lamps.fault || lamps.inputs == $past(status.input_active);
  endproperty
  property p_alert_safe;
    alert.sync_alert || alert.lock_alert |=> safe_state;
  endproperty
  property p_sync;
    s_sync ##1 s_sync |-> lamps.inputs[0] != lamps.inputs[1] && lamps.fault == lamps.inputs[0];
  endproperty
  property p_lock;
    s_lock ##1 s_lock |-> lamps.inputs[3:2] == {2{lamps.fault}};
  endproperty
  // inputs still active when the alert ends: at least eight more cycles held
  property p_hold;
    $fell(alert.lock_alert) && |(status.input_active & $past(alert.inputs)) |-> safe_state[*8];
  endproperty
  property p_err;
    err_q |=> safe_state && lamps.fault;
  endproperty
  property p_blink;
    $fell(lamps.start) && run_q > 3 * BLINK_HALF_CYC |-> hi_q == BLINK_HALF_CYC;
  endproperty

  a_state: assert property (p_state) else $error("state lamp wrong");
  a_start: assert property (p_start) else $error("start lamp wrong");
  a_inputs: assert property (p_inputs) else $error("input lamps wrong");
  a_alert_safe: assert property (p_alert_safe) else $error("alert without safe state");
  a_sync: assert property (p_sync) else $error("sync alert phase wrong");
  a_lock: assert property (p_lock) else $error("interlock phase wrong");
  a_hold: assert property (p_hold) else $error("interlock hold too short");
  a_err: assert property (p_err) else $error("error not latched");
  a_blink: assert property (p_blink) else $error("blink half period wrong");
endmodule : sled_diag_asserts

// [verif/sled_diag_bench.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end

module sled_diag_bench;
  localparam int BLINK = 4;
  localparam int LOCK  = 8;

  logic                      mclk      = 1'b0;
  logic                      srst      = 1'b1;
  sled_pkg::sled_status_type status    = '0;
  sled_pkg::sled_alert_type  alert     = '0;
  sled_pkg::sled_error_type  error     = '0;
  logic [3:0]                sel_app   = 4'h5;
  logic [3:0]                sel_start = 4'h3;
  logic [7:0]                reg_addr  = 8'h00;
  logic [31:0]               reg_wdata = 32'h0;
  logic                      reg_wr    = 1'b0;
  logic                      reg_rd    = 1'b0;
  logic                      clear     = 1'b0;
  logic [31:0]               reg_rdata;
  sled_pkg::sled_lamp_type   lamps;
  logic                      safe_state;
  logic                      irq;
  logic [9:0]                seen_on;
  logic [9:0]                seen_off;
  logic [31:0]               rd;
  int                        err_total  = 0;
  int                        n_compared = 0;

  always #25 mclk = ~mclk;

  sled_diag #(.LOCK_OFF_CYC(LOCK), .BLINK_HALF_CYC(BLINK)) u_dut (
    .mclk(mclk), .srst(srst), .status(status), .alert(alert), .error(error),
    .sel_app_pin(sel_app), .sel_start_pin(sel_start), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .lamps(lamps), .safe_state(safe_state), .irq(irq));
  sled_operator u_eye (.mclk(mclk), .clear(clear), .lamps(lamps), .seen_on(seen_on),
    .seen_off(seen_off));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic do_reset;
    @(posedge mclk);
    srst   <= 1'b1;
    status <= '0;
    alert  <= '0;
    error  <= '0;
    cyc(5);
    srst <= 1'b0;
  endtask : do_reset

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rd_reg

  // window long enough for two full blink periods
  task automatic look(input logic [9:0] care, input logic [9:0] lit, input logic [9:0] blk,
                      input string nm);
    @(posedge mclk) clear <= 1'b1;
    @(posedge mclk) clear <= 1'b0;
    cyc(4 * BLINK + 2);
    #1;
    `CHK(nm, lit, seen_on & ~seen_off & care)
    `CHK(nm, blk, seen_on & seen_off & care)
  endtask : look

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_status;
    do_reset();
    @(posedge mclk) status <= 9'h12a;
    look(10'h1ff, 10'h0aa, 10'h000, "lamps active");
    @(posedge mclk) status <= 9'h095;
    look(10'h1ff, 10'h055, 10'h000, "lamps met");
    @(posedge mclk) status <= 9'h040;
    look(10'h1ff, 10'h000, 10'h040, "lamps wait");
  endtask : t_status

  task automatic t_sync;
    @(posedge mclk) begin
      status <= 9'h003;
      alert  <= 8'h83;
    end
    look(10'h103, 10'h000, 10'h103, "sync lamps");
    `CHK("sync safe", 1'b1, safe_state)
    @(posedge mclk) alert <= '0;
    cyc(3);
    #1 `CHK("sync exit", 1'b0, safe_state)
  endtask : t_sync

  task automatic t_lock;
    int n;
    @(posedge mclk) begin
      status <= 9'h00c;
      alert  <= 8'h4c;
    end
    look(10'h10c, 10'h000, 10'h10c, "lock lamps");
    @(posedge mclk) alert <= '0;
    cyc(LOCK + 4);
    #1 `CHK("lock held", 1'b1, safe_state)
    @(posedge mclk) status <= '0;
    cyc(LOCK - 1);
    #1 `CHK("lock early", 1'b1, safe_state)
    n = 0;
    while (safe_state !== 1'b0 && n < 4) begin
      @(posedge mclk);
      #1 n++;
    end
    `CHK("lock release", 1'b0, safe_state)
    if (safe_state !== 1'b0) final_report();
    rd_reg(sled_pkg::REG_IRQ_STATUS);
    `CHK("lock done irq", 1'b1, rd[sled_pkg::IRQ_LOCK_DONE])
  endtask : t_lock

  task automatic t_errors;
    logic [10:0] ev [7] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h040, 11'h010, 11'h003};
    logic [9:0]  bl [7] = '{10'h0ff, 10'h200, 10'h080, 10'h0c0, 10'h040, 10'h010, 10'h003};
    for (int k = 0; k < 7; k++) begin
      do_reset();
      @(posedge mclk) begin
        status <= 9'h13f;
        alert  <= 8'h83;
        error  <= ev[k];
      end
      @(posedge mclk) error <= '0;
      look({k == 1, 9'h1ff}, 10'h100, bl[k], "errors");
      `CHK("error safe", 1'b1, safe_state)
    end
  endtask : t_errors

  task automatic t_config;
    do_reset();
    cyc(6);
    rd_reg(sled_pkg::REG_SELECT);
    `CHK("selector", 32'h153, rd)
    @(posedge mclk) sel_app <= 4'ha;
    cyc(4);
    look(10'h1ff, 10'h1ff, 10'h000, "config lamps");
    `CHK("config safe", 1'b1, safe_state)
  endtask : t_config

  task automatic t_regs;
    do_reset();
    rd_reg(sled_pkg::REG_IRQ_ENABLE);
    `CHK("enable reset", 32'h0, rd)
    rd_reg(8'h20);
    `CHK("unmapped", 32'h0, rd)
    @(posedge mclk) error <= 11'h200;
    @(posedge mclk) error <= '0;
    cyc(3);
    #1 `CHK("irq masked", 1'b0, irq)
    rd_reg(sled_pkg::REG_IRQ_STATUS);
    `CHK("irq status", 1'b1, rd[sled_pkg::IRQ_ERROR])
    rd_reg(sled_pkg::REG_ERRORS);
    `CHK("power error bit", 1'b1, rd[sled_pkg::ERR_POWER])
    wr_reg(sled_pkg::REG_IRQ_ENABLE, 32'h4);
    #1 `CHK("irq raised", 1'b1, irq)
    wr_reg(sled_pkg::REG_IRQ_CLEAR, 32'h4);
    #1 `CHK("irq cleared", 1'b0, irq)
    rd_reg(sled_pkg::REG_LAMPS);
    `CHK("fault in word", 1'b1, rd[sled_pkg::LAMP_FAULT])
  endtask : t_regs

  initial begin
    cyc(5);
    srst <= 1'b0;
    t_status();
    t_sync();
    t_lock();
    t_errors();
    t_config();
    t_regs();
    final_report();
  end

  initial begin
    cyc(100000);
    err_total++;
    final_report();
  end
endmodule : sled_diag_bench

bind sled_diag sled_diag_asserts #(.BLINK_HALF_CYC(BLINK_HALF_CYC)) u_chk (
  .mclk(mclk), .srst(srst), .status(status), .alert(alert), .error(error),
  .lamps(lamps), .safe_state(safe_state));

// [verif/sled_operator.sv]
`timescale 1ns/1ps
// ****************************************************************
// operator watching the lamps
// ****************************************************************
module sled_operator (
  // clock
  input wire logic                    mclk,
  // restart of observation
  input wire logic                    clear,
  // lamps
  input wire sled_pkg::sled_lamp_type lamps,
  // seen lit and seen dark over the window
  output logic [9:0]                  seen_on,
  output logic [9:0]                  seen_off
);
  // lit only means solid, both means flashing
  always_ff @(posedge mclk) begin
    if (clear) begin
      seen_on  <= 10'h000;
      seen_off <= 10'h000;
    end else begin
      seen_on  <= seen_on | lamps;
      seen_off <= seen_off | ~lamps;
    end
  end
endmodule : sled_operator
